/* File: common/cid_defines.svh */
`ifndef CID_DEFINES_SVH
`define CID_DEFINES_SVH

// register byte offsets on the plain register port
`define CID_ADDR_W        13
`define CID_OFS_CTRL      13'h000
`define CID_OFS_STAT      13'h004
`define CID_OFS_IIDR      13'h0FC
`define CID_OFS_GRP       13'h100
`define CID_GRP_MASK      13'h1F80
`define CID_GRP_IDX       6:2
`define CID_OFS_DIR       13'h1000

// interface control bit positions
`define CID_CTRL_S        0
`define CID_CTRL_NS       1

// deactivation word fields
`define CID_DIR_ID        9:0
`define CID_DIR_SRC       12:10
`define CID_SWI_LIMIT     10'h010
`define CID_SPURIOUS_MIN  10'h3FC

// status word fields
`define CID_STAT_LAST     25:16
`define CID_STAT_IGN      15:0

// identification word fields and values (values arbitrary)
`define CID_IIDR_PROD     31:20
`define CID_IIDR_ARCH     19:16
`define CID_IIDR_REV      15:12
`define CID_IIDR_IMPL     11:0
`define CID_PRODUCT       12'h000
`define CID_REVISION      4'h0
`define CID_JEP_CONT      4'h0
`define CID_JEP_IDENT     7'h00
`define CID_ARCH_V1       4'h1
`define CID_ARCH_V2       4'h2

// sizes and reset values
`define CID_WORD_W        32
`define CID_NUM_INT       1024
`define CID_RST_STATE     '0

`endif

/* File: common/cid_pkg.sv */
`include "cid_defines.svh"

package cid_pkg;

  // register selected by an address
  typedef enum logic [2:0] {
    CID_REG_NONE, CID_REG_CTRL, CID_REG_STAT,
    CID_REG_IIDR, CID_REG_GRP, CID_REG_DIR
  } cid_reg_t;

  // fate of one deactivation write
  typedef enum logic [2:0] {
    CID_V_DEACT, CID_V_ARCH, CID_V_MODE, CID_V_SPUR, CID_V_GROUP
  } cid_verdict_t;

  // all state of the interface core
  typedef struct packed {
    logic                      splitS;
    logic                      splitNs;
    logic [`CID_NUM_INT-1:0]   grp1;
    logic [`CID_WORD_W-1:0]    rdData;
    logic                      deactValid;
    logic [9:0]                deactId;
    logic [2:0]                deactSrc;
    logic                      deactSecure;
    logic [9:0]                lastId;
    logic [15:0]               ignCount;
  } cid_state_t;

endpackage

/* File: logic/cid_id_word.sv */
`timescale 1ns/1ps
// builds the constant identification word
module cid_id_word
  import cid_pkg::*;
#(
  parameter logic [3:0] ARCH_VER = `CID_ARCH_V2
) (
  // identification word out
  output logic [`CID_WORD_W-1:0] idWord
);

  // fixed fields, bit 7 of the maker code is always zero
  always_comb begin
    idWord                  = '0;
    idWord[`CID_IIDR_PROD]  = `CID_PRODUCT; // RULE1
    idWord[`CID_IIDR_ARCH]  = ARCH_VER; // RULE2
    idWord[`CID_IIDR_REV]   = `CID_REVISION; // RULE3
    idWord[`CID_IIDR_IMPL]  = {`CID_JEP_CONT, 1'b0, `CID_JEP_IDENT}; // RULE4
  end

endmodule // cid_id_word

/* File: logic/cid_deact_filter.sv */
`timescale 1ns/1ps
// decides whether one deactivation write takes effect
module cid_deact_filter
  import cid_pkg::*;
#(
  parameter bit         SEC_EXT  = 1'b1,
  parameter logic [3:0] ARCH_VER = `CID_ARCH_V2
) (
  // write context
  input  wire logic                   accSecure,
  input  wire logic                   splitS,
  input  wire logic                   splitNs,
  input  wire logic [`CID_WORD_W-1:0] wrWord,
  input  wire logic                   grpIsOne,
  // decision
  output logic [9:0]                  intId,
  output logic [2:0]                  srcCpu,
  output cid_verdict_t                verdict
);

  logic secView;  // access sees the secure copy of control
  logic modeOn;   // split end-of-interrupt mode for this access

  // one shared register serves both states; the state only picks the bit
  always_comb begin
    intId   = wrWord[`CID_DIR_ID]; // RULE13
    // source field only means something for software interrupts
    srcCpu  = (intId < `CID_SWI_LIMIT) ? wrWord[`CID_DIR_SRC] : '0; // RULE14
    secView = !SEC_EXT || accSecure;
    modeOn  = secView ? splitS : splitNs; // RULE7 RULE8
    if (ARCH_VER == `CID_ARCH_V1) begin
      verdict = CID_V_ARCH; // RULE15
    end else if (!modeOn) begin
      verdict = CID_V_MODE; // RULE7 RULE8
    end else if (intId >= `CID_SPURIOUS_MIN) begin
      verdict = CID_V_SPUR;
    end else if (!secView && !grpIsOne) begin
      verdict = CID_V_GROUP; // RULE16
    end else begin
      verdict = CID_V_DEACT; // RULE6
    end
  end

endmodule // cid_deact_filter

/* File: logic/cid_iface_core.sv */
`timescale 1ns/1ps
// Functional notes
// RULE1: identification top twelve bits hold product code
// RULE2: architecture field reads one or two
// RULE3: four-bit revision field of this interface
// RULE4: low twelve bits hold maker code, bit7 zero
// RULE5: identification present always, one shared copy
// RULE6: split mode write deactivates named interrupt
// RULE7: no security: split bit must be one
// RULE8: secure and nonsecure writes check own bit
// RULE9: software never writes while split bit zero
// RULE10: software names only ended active or spurious
// RULE11: deactivation writes accepted in any order
// RULE12: software writes back the acknowledge word
// RULE13: id bits 9:0, source 12:10, rest zero
// RULE14: source field zero except software interrupts
// RULE15: deactivation only in version two, shared
// RULE16: nonsecure write deactivates group one only
// RULE17: identification writes ignored, deactivation reads zero
module cid_iface_core
  import cid_pkg::*;
#(
  parameter bit         SEC_EXT  = 1'b1,
  parameter logic [3:0] ARCH_VER = `CID_ARCH_V2
) (
  // clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    arst_n,
  // register port
  input  wire logic [`CID_ADDR_W-1:0]  busAddr,
  input  wire logic [`CID_WORD_W-1:0]  busWrData,
  input  wire logic                    busWrEn,
  input  wire logic                    busRdEn,
  input  wire logic                    busSecure,
  output logic      [`CID_WORD_W-1:0]  busRdData,
  // deactivation towards the distributor
  output logic                         deactValid,
  output logic      [9:0]              deactId,
  output logic      [2:0]              deactSrc,
  output logic                         deactSecure,
  // current split end-of-interrupt modes
  output logic                         secureSplitEoiMode,
  output logic                         nonsecureSplitEoiMode
);

  // address decode, shared by the write and the read path
  function automatic cid_reg_t decodeReg(
    input logic [`CID_ADDR_W-1:0] addr
  );
    cid_reg_t r;
    r = CID_REG_NONE;
    if (addr == `CID_OFS_CTRL) begin
      r = CID_REG_CTRL;
    end else if (addr == `CID_OFS_STAT) begin
      r = CID_REG_STAT;
    end else if (addr == `CID_OFS_IIDR) begin
      r = CID_REG_IIDR;
    end else if ((addr & `CID_GRP_MASK) == `CID_OFS_GRP) begin
      r = CID_REG_GRP;
    end else if (addr == `CID_OFS_DIR) begin
      r = CID_REG_DIR;
    end
    return r;
  endfunction

  cid_state_t               stReg;      // registered state
  cid_state_t               stNext;     // next state
  cid_reg_t                 wrSel;      // register hit by a write
  cid_reg_t                 rdSel;      // register hit by a read
  logic                     secView;    // access sees the secure view
  logic [`CID_WORD_W-1:0]   idWord;     // identification value
  logic [`CID_NUM_INT-1:0]  grpNext;    // group bits after a group write
  logic [`CID_WORD_W-1:0]   grpRdWord;  // group word addressed by a read
  logic [9:0]               fltId;      // id taken from the write
  logic [2:0]               fltSrc;     // source field after masking
  cid_verdict_t             verdict;    // fate of a deactivation write
  logic                     grpIsOne;   // named interrupt is group one

  assign wrSel   = decodeReg(busAddr);
  assign rdSel   = decodeReg(busAddr);
  // without security every access is treated as the secure one
  assign secView = !SEC_EXT || busSecure;

  // one identification copy for every access state
  cid_id_word #(
    .ARCH_VER (ARCH_VER)
  ) uIdWord (
    .idWord   (idWord) // RULE5
  );

  // group of the interrupt named in the written word
  assign grpIsOne = stReg.grp1[busWrData[`CID_DIR_ID]];

  // deactivation decision, one shared register for both states
  cid_deact_filter #(
    .SEC_EXT   (SEC_EXT),
    .ARCH_VER  (ARCH_VER)
  ) uFilter (
    .accSecure (busSecure),
    .splitS    (stReg.splitS),
    .splitNs   (stReg.splitNs),
    .wrWord    (busWrData),
    .grpIsOne  (grpIsOne),
    .intId     (fltId),
    .srcCpu    (fltSrc),
    .verdict   (verdict)
  );

  // per-word write of the group bits; other words keep their value
  genvar g;
  generate
    for (g = 0; g < `CID_NUM_INT / `CID_WORD_W; g++) begin : gGrp
      assign grpNext[g*`CID_WORD_W +: `CID_WORD_W] =
        (busAddr[`CID_GRP_IDX] == 5'(g)) ? busWrData
        : stReg.grp1[g*`CID_WORD_W +: `CID_WORD_W];
    end
  endgenerate

  // read of one group word
  assign grpRdWord =
    stReg.grp1[{busAddr[`CID_GRP_IDX], 5'h00} +: `CID_WORD_W];

  // next state: register writes, deactivation and the read answer
  always_comb begin
    stNext            = stReg;
    // deactivation is a single-cycle pulse
    stNext.deactValid = 1'b0;
    // read data live for one cycle only
    stNext.rdData     = '0;

    if (busWrEn) begin
      case (wrSel)
        CID_REG_CTRL: begin
          // nonsecure access may only touch its own mode bit
          if (secView) begin
            stNext.splitS  = busWrData[`CID_CTRL_S];
            stNext.splitNs = busWrData[`CID_CTRL_NS];
          end else begin
            stNext.splitNs = busWrData[`CID_CTRL_NS];
          end
        end
        CID_REG_GRP: begin
          // group assignment is a secure-only setting
          if (secView) begin
            stNext.grp1 = grpNext;
          end
        end
        CID_REG_DIR: begin
          // no ordering check: each write stands on its own
          if (verdict == CID_V_DEACT) begin // RULE11
            stNext.deactValid  = 1'b1; // RULE6
            stNext.deactId     = fltId; // RULE13
            stNext.deactSrc    = fltSrc; // RULE14
            stNext.deactSecure = secView && SEC_EXT;
            stNext.lastId      = fltId;
          end else begin
            // ignored writes are only counted, never acted on
            stNext.ignCount = stReg.ignCount + 16'h0001; // RULE16
          end
        end
        CID_REG_IIDR: begin
          // the identification value is fixed
          stNext.ignCount = stReg.ignCount; // RULE17
        end
        default: begin
          // unmapped writes do nothing
          stNext.ignCount = stReg.ignCount;
        end
      endcase
    end

    if (busRdEn) begin
      case (rdSel)
        CID_REG_CTRL: begin
          // nonsecure view hides the secure mode bit
          stNext.rdData[`CID_CTRL_NS] = stReg.splitNs;
          stNext.rdData[`CID_CTRL_S]  = secView && stReg.splitS;
        end
        CID_REG_STAT: begin
          stNext.rdData[`CID_STAT_LAST] = stReg.lastId;
          stNext.rdData[`CID_STAT_IGN]  = stReg.ignCount;
        end
        CID_REG_IIDR: begin
          stNext.rdData = idWord; // RULE5
        end
        CID_REG_GRP: begin
          stNext.rdData = secView ? grpRdWord : '0;
        end
        CID_REG_DIR: begin
          // write-only: reads give zero and change nothing
          stNext.rdData = '0; // RULE17
        end
        default: begin
          stNext.rdData = '0;
        end
      endcase
    end
  end

  // single state register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stReg <= `CID_RST_STATE;
    end else begin
      stReg <= stNext;
    end
  end

  // outputs straight from the state flops
  assign busRdData             = stReg.rdData;
  assign deactValid            = stReg.deactValid;
  assign deactId               = stReg.deactId;
  assign deactSrc              = stReg.deactSrc;
  assign deactSecure           = stReg.deactSecure;
  assign secureSplitEoiMode    = stReg.splitS;
  assign nonsecureSplitEoiMode = stReg.splitNs;

  // checks on the behaviour above
  default clocking cbCore @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // identification read returns the product code
  a_iidr_product: assert property ( // RULE1
    busRdEn && busAddr == `CID_OFS_IIDR |=>
      busRdData[`CID_IIDR_PROD] == `CID_PRODUCT
  ) else $error("product field wrong");

  // identification read returns the architecture version
  a_iidr_arch: assert property ( // RULE2
    busRdEn && busAddr == `CID_OFS_IIDR |=>
      busRdData[`CID_IIDR_ARCH] == ARCH_VER
  ) else $error("architecture field wrong");

  // revision and maker code, bit 7 clear
  a_iidr_low_fields: assert property ( // RULE3 RULE4
    busRdEn && busAddr == `CID_OFS_IIDR |=>
      busRdData[`CID_IIDR_REV] == `CID_REVISION &&
      busRdData[`CID_IIDR_IMPL] ==
        {`CID_JEP_CONT, 1'b0, `CID_JEP_IDENT}
  ) else $error("revision or maker field wrong");

  // valid secure write deactivates the written id next cycle
  a_deact_secure_id: assert property ( // RULE6
    busWrEn && busAddr == `CID_OFS_DIR && secView &&
    stReg.splitS && ARCH_VER == `CID_ARCH_V2 &&
    busWrData[`CID_DIR_ID] < `CID_SPURIOUS_MIN |=>
      deactValid && deactId == $past(busWrData[`CID_DIR_ID])
  ) else $error("secure deactivation lost");

  // mode bit clear for the access means no deactivation
  a_deact_mode_off: assert property ( // RULE8
    busWrEn && busAddr == `CID_OFS_DIR &&
    !(secView ? stReg.splitS : stReg.splitNs) |=> !deactValid
  ) else $error("deactivation with split mode off");

  // nonsecure write naming a group zero interrupt is dropped
  a_deact_ns_group: assert property ( // RULE16
    busWrEn && busAddr == `CID_OFS_DIR && !secView &&
    !stReg.grp1[busWrData[`CID_DIR_ID]] |=>
      !deactValid ##0 $changed(stReg.ignCount)
  ) else $error("group zero deactivated by nonsecure write");

  // source field cleared for anything but software interrupts
  a_swi_source: assert property ( // RULE14
    deactValid && deactId >= `CID_SWI_LIMIT |-> deactSrc == 3'h0
  ) else $error("source field not cleared");

  // read of the deactivation location returns zero
  a_dir_read_zero: assert property ( // RULE17
    busRdEn && busAddr == `CID_OFS_DIR |=> busRdData == '0
  ) else $error("deactivation register read not zero");

  // version one has no deactivation register
  a_v1_no_dir: assert property ( // RULE15
    busWrEn && busAddr == `CID_OFS_DIR &&
    ARCH_VER == `CID_ARCH_V1 |=> !deactValid
  ) else $error("deactivation in version one");

  // back-to-back valid writes each give their own pulse
  a_back_to_back: assert property ( // RULE11
    deactValid && busWrEn && busAddr == `CID_OFS_DIR &&
    verdict == CID_V_DEACT |=> deactValid
  ) else $error("second deactivation refused");

  // a valid nonsecure write to a group one interrupt goes through
  a_deact_ns_hit: assert property ( // RULE16
    busWrEn && busAddr == `CID_OFS_DIR && !secView &&
    stReg.splitNs && ARCH_VER == `CID_ARCH_V2 &&
    busWrData[`CID_DIR_ID] < `CID_SPURIOUS_MIN &&
    stReg.grp1[busWrData[`CID_DIR_ID]] |=>
      deactValid && !deactSecure
  ) else $error("nonsecure group one deactivation lost");

  // without security the group of the interrupt does not matter
  a_nosec_any_group: assert property ( // RULE7
    !SEC_EXT && busWrEn && busAddr == `CID_OFS_DIR &&
    stReg.splitS && ARCH_VER == `CID_ARCH_V2 &&
    busWrData[`CID_DIR_ID] < `CID_SPURIOUS_MIN |=>
      deactValid && deactId == $past(busWrData[`CID_DIR_ID])
  ) else $error("deactivation refused without security");

  // software interrupts keep the written source field
  a_swi_source_kept: assert property ( // RULE14
    busWrEn && busAddr == `CID_OFS_DIR && verdict == CID_V_DEACT &&
    busWrData[`CID_DIR_ID] < `CID_SWI_LIMIT |=>
      deactSrc == $past(busWrData[`CID_DIR_SRC])
  ) else $error("source field lost");

  // reserved and spurious ids never deactivate anything
  a_spurious_drop: assert property ( // RULE6
    busWrEn && busAddr == `CID_OFS_DIR &&
    busWrData[`CID_DIR_ID] >= `CID_SPURIOUS_MIN |=> !deactValid
  ) else $error("spurious id deactivated");

  // a nonsecure control write leaves the secure mode bit alone
  a_ctrl_ns_keep: assert property ( // RULE8
    busWrEn && busAddr == `CID_OFS_CTRL && !secView |=>
      secureSplitEoiMode == $past(stReg.splitS)
  ) else $error("secure split mode changed by nonsecure write");

  // the pulse lasts one cycle unless a new write is accepted
  a_pulse_single: assert property ( // RULE6
    deactValid && !(busWrEn && busAddr == `CID_OFS_DIR) |=> !deactValid
  ) else $error("deactivation pulse stretched");

  // revision field is the fixed value of this interface
  a_iidr_revision: assert property ( // RULE3
    busRdEn && busAddr == `CID_OFS_IIDR |=>
      busRdData[`CID_IIDR_REV] == `CID_REVISION
  ) else $error("revision field wrong");

  // identification writes leave every setting and count alone
  a_iidr_write_ign: assert property ( // RULE17
    busWrEn && busAddr == `CID_OFS_IIDR |=>
      !deactValid && $stable(stReg.ignCount) && $stable(stReg.grp1)
      && $stable({stReg.splitS, stReg.splitNs})
  ) else $error("identification write had an effect");

  // accepted writes report the security state of the access
  a_deact_sec_flag: assert property ( // RULE8
    busWrEn && busAddr == `CID_OFS_DIR && verdict == CID_V_DEACT |=>
      deactSecure == $past(SEC_EXT && busSecure)
  ) else $error("security state of deactivation wrong");

endmodule // cid_iface_core

/* File: test/cid_cpu_model.sv */
`timescale 1ns/1ps
// processor-side register master driving the interface core
module cid_cpu_model (
  // clock and returned read data
  input  wire logic        core_clk,
  input  wire logic [31:0] busRdData,
  // register port towards the core
  output logic      [12:0] busAddr,
  output logic      [31:0] busWrData,
  output logic             busWrEn,
  output logic             busRdEn,
  output logic             busSecure
);
  // idle values at time zero, no strobe
  initial begin
    busAddr   = 13'h0000;
    busWrData = 32'h0000_0000;
    busWrEn   = 1'h0;
    busRdEn   = 1'h0;
    busSecure = 1'h0;
  end

  // one-cycle write; idle lines flip so stale data never looks valid
  task automatic wr(input logic [12:0] a, input logic [31:0] d,
                    input logic s);
    @(posedge core_clk);
    busWrEn   <= 1'h1;
    busAddr   <= a;
    busWrData <= d;
    busSecure <= s;
    @(posedge core_clk);
    busWrEn   <= 1'h0;
    busAddr   <= ~a;
    busWrData <= ~d;
  endtask

  // two writes with no gap, the strobe stays high across both
  task automatic wr_pair(input logic [12:0] a, input logic [31:0] d0,
                         input logic [31:0] d1, input logic s);
    @(posedge core_clk);
    busWrEn   <= 1'h1;
    busAddr   <= a;
    busWrData <= d0;
    busSecure <= s;
    @(posedge core_clk);
    busWrData <= d1;
    @(posedge core_clk);
    busWrEn   <= 1'h0;
    busAddr   <= ~a;
    busWrData <= ~d1;
  endtask

  // one-cycle read; data taken in the following cycle only
  task automatic rd(input logic [12:0] a, input logic s,
                    output logic [31:0] d);
    @(posedge core_clk);
    busRdEn   <= 1'h1;
    busAddr   <= a;
    busSecure <= s;
    @(posedge core_clk);
    busRdEn   <= 1'h0;
    busAddr   <= ~a;
    #1 d = busRdData;
  endtask
endmodule // cid_cpu_model

/* File: test/cid_iface_core_test.sv */
`timescale 1ns/1ps
`include "cid_defines.svh"
// self-checking bench for the identification and deactivation registers
module cid_iface_core_test;
  // clock, reset and bus
  logic        core_clk = 1'h0;
  logic        arst_n   = 1'h0;
  logic [12:0] busAddr;
  logic [31:0] busWrData;
  logic        busWrEn;
  logic        busRdEn;
  logic        busSecure;
  logic [31:0] busRdData;
  logic        deactValid;
  logic [9:0]  deactId;
  logic [2:0]  deactSrc;
  logic        deactSecure;
  logic        splitS;
  logic        splitNs;
  // version one instance shares the bus
  logic [31:0] v1RdData;
  logic        v1Deact;
  logic        v1Seen = 1'h0;
  // no-security instance shares the bus as well
  logic        nsDeact;
  logic        nsSplit;
  int          nsCount = 0;
  // bookkeeping
  int          n_mismatch = 0;
  int          checked    = 0;
  logic [31:0] rdv;
  logic [31:0] idV2;
  logic [31:0] idV1;

  // one deactivation case: word, access, expected pulse and fields
  typedef struct packed {
    logic [31:0] data;
    logic        sec;
    logic        hit;
    logic [9:0]  id;
    logic [2:0]  src;
  } cid_row_t;
  localparam int NROW = 7;
  cid_row_t rows [NROW] = '{
    '{32'h0000_0405, 1'h1, 1'h1, 10'h005, 3'h1},
    '{32'h0000_0C07, 1'h1, 1'h1, 10'h007, 3'h3},
    '{32'h0000_0C05, 1'h0, 1'h1, 10'h005, 3'h3},
    '{32'h0000_0007, 1'h0, 1'h0, 10'h000, 3'h0},
    '{32'h0000_1420, 1'h1, 1'h1, 10'h020, 3'h0},
    '{32'h0000_03FC, 1'h1, 1'h0, 10'h000, 3'h0},
    '{32'h0000_03FF, 1'h1, 1'h0, 10'h000, 3'h0}};

  always #2.5 core_clk = ~core_clk;

  cid_cpu_model i_cpu (.core_clk(core_clk), .busRdData(busRdData),
    .busAddr(busAddr), .busWrData(busWrData), .busWrEn(busWrEn),
    .busRdEn(busRdEn), .busSecure(busSecure));

  cid_iface_core i_dut (.core_clk(core_clk), .arst_n(arst_n),
    .busAddr(busAddr), .busWrData(busWrData), .busWrEn(busWrEn),
    .busRdEn(busRdEn), .busSecure(busSecure), .busRdData(busRdData),
    .deactValid(deactValid), .deactId(deactId), .deactSrc(deactSrc),
    .deactSecure(deactSecure), .secureSplitEoiMode(splitS),
    .nonsecureSplitEoiMode(splitNs));

  cid_iface_core #(.ARCH_VER(`CID_ARCH_V1)) i_v1 (.core_clk(core_clk),
    .arst_n(arst_n), .busAddr(busAddr), .busWrData(busWrData),
    .busWrEn(busWrEn), .busRdEn(busRdEn), .busSecure(busSecure),
    .busRdData(v1RdData), .deactValid(v1Deact), .deactId(),
    .deactSrc(), .deactSecure(), .secureSplitEoiMode(),
    .nonsecureSplitEoiMode());

  cid_iface_core #(.SEC_EXT(1'b0)) i_nosec (.core_clk(core_clk),
    .arst_n(arst_n), .busAddr(busAddr), .busWrData(busWrData),
    .busWrEn(busWrEn), .busRdEn(busRdEn), .busSecure(busSecure),
    .busRdData(), .deactValid(nsDeact), .deactId(), .deactSrc(),
    .deactSecure(), .secureSplitEoiMode(nsSplit),
    .nonsecureSplitEoiMode());

  // sticky record of any version one pulse, count of no-security pulses
  always @(posedge core_clk) begin
    if (v1Deact === 1'h1) begin
      v1Seen <= 1'h1;
    end
    if (nsDeact === 1'h1) begin
      nsCount <= nsCount + 1;
    end
  end

  // compare one bus or status word
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // compare the deactivation outputs; fields only matter on a pulse
  task automatic chk_deact(input logic hit, input logic [9:0] id,
                           input logic [2:0] src, input logic sec);
    logic [14:0] got;
    logic [14:0] exp;
    got = hit ? {deactValid, deactId, deactSrc, deactSecure}
              : {deactValid, 14'h0000};
    exp = {hit, hit ? {id, src, sec} : 14'h0000};
    chk_word({17'h00000, got}, {17'h00000, exp});
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  // single closing point of the run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog well beyond the few dozen cycles the tests need
  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end

  // main sequence
  initial begin
    int       ign;
    cid_row_t r;
    ign  = 0;
    idV2 = {`CID_PRODUCT, `CID_ARCH_V2, `CID_REVISION, `CID_JEP_CONT,
            1'h0, `CID_JEP_IDENT};
    idV1 = {`CID_PRODUCT, `CID_ARCH_V1, `CID_REVISION, `CID_JEP_CONT,
            1'h0, `CID_JEP_IDENT};
    repeat (5) @(posedge core_clk);
    chk_word(busRdData, 32'h0000_0000);
    chk_word({15'h0000, deactValid, deactId, deactSrc, deactSecure, splitS,
              splitNs}, 32'h0000_0000);
    arst_n <= 1'h1;
    done("reset");
    // both split bits on, interrupt 5 in group one
    i_cpu.wr(`CID_OFS_CTRL, 32'h0000_0003, 1'h1);
    #1 chk_word({30'h0000_0000, splitS, splitNs}, 32'h0000_0003);
    i_cpu.wr(`CID_OFS_GRP, 32'h0000_0020, 1'h1);
    for (int i = 0; i < NROW; i++) begin
      r = rows[i];
      i_cpu.wr(`CID_OFS_DIR, r.data, r.sec);
      #1 chk_deact(r.hit, r.id, r.src, r.sec);
      if (r.hit !== 1'h1) begin
        ign++;
      end
    end
    i_cpu.rd(`CID_OFS_STAT, 1'h1, rdv);
    chk_word(rdv, {6'h00, 10'h020, ign[15:0]});
    done("deactivate table");
    // identification word, both views, write ignored, both versions
    i_cpu.wr(`CID_OFS_IIDR, 32'hFFFF_FFFF, 1'h1);
    i_cpu.rd(`CID_OFS_IIDR, 1'h1, rdv);
    chk_word(rdv, idV2);
    chk_word(v1RdData, idV1);
    i_cpu.rd(`CID_OFS_IIDR, 1'h0, rdv);
    chk_word(rdv, idV2);
    #5 chk_word(busRdData, 32'h0000_0000);
    done("identification");
    // write-only and unmapped places read zero
    i_cpu.rd(`CID_OFS_DIR, 1'h1, rdv);
    chk_word(rdv, 32'h0000_0000);
    i_cpu.rd(13'h0008, 1'h1, rdv);
    chk_word(rdv, 32'h0000_0000);
    done("read zero");
    // nonsecure clears only its own bit, then its writes are dropped
    i_cpu.wr(`CID_OFS_CTRL, 32'h0000_0000, 1'h0);
    #1 chk_word({30'h0000_0000, splitS, splitNs}, 32'h0000_0002);
    chk_word({31'h0000_0000, nsSplit}, 32'h0000_0000);
    i_cpu.wr(`CID_OFS_DIR, 32'h0000_0005, 1'h0);
    #1 chk_deact(1'h0, 10'h000, 3'h0, 1'h0);
    i_cpu.wr(`CID_OFS_DIR, 32'h0000_0009, 1'h1);
    #1 chk_deact(1'h1, 10'h009, 3'h0, 1'h1);
    chk_word({31'h0000_0000, v1Seen}, 32'h0000_0000);
    done("split mode");
    // two accepted writes with no gap give two pulses in a row
    fork
      i_cpu.wr_pair(`CID_OFS_DIR, 32'h0000_080B, 32'h0000_000D, 1'h1);
      begin
        @(posedge core_clk);
        @(posedge core_clk);
        #1 chk_deact(1'h1, 10'h00B, 3'h2, 1'h1);
      end
    join
    #1 chk_deact(1'h1, 10'h00D, 3'h0, 1'h1);
    // no-security copy ignored groups, then obeyed its single bit
    chk_word(nsCount, 32'h0000_0005);
    done("back to back");
    wrap_up();
  end
endmodule // cid_iface_core_test
